/* hdl/lin_frame_ctrl_pkg.sv */
// shared constants and types for the lin frame request block
package lin_frame_ctrl_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int          CHANS        = 4;
  localparam int          ADDR_W       = 12;
  localparam int          IDX_W        = 10;
  localparam int          ERR_W        = 5;
  localparam int          STAT_W       = 2;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0]  IDX_IRQ_EN   = 10'h038;
  localparam logic [9:0]  IDX_REQ      = 10'h039;
  localparam logic [9:0]  IDX_ID       = 10'h03a;
  localparam logic [9:0]  IDX_FMT      = 10'h03b;
  localparam logic [9:0]  CHAN_STRIDE  = 10'h030;
  localparam logic [9:0]  IDX_GLB_EN   = 10'h020;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          B_STUCK      = 7;
  localparam int          B_TMO        = 6;
  localparam int          B_RDBK       = 5;
  localparam int          B_SUM        = 4;
  localparam int          B_RXD        = 2;
  localparam int          B_TXD        = 1;
  localparam int          B_FRM        = 0;
  localparam int          B_WAKE       = 4;
  localparam int          B_ABORT      = 1;
  localparam int          B_HDR        = 0;
  localparam int          ID_MSB       = 5;
  localparam int          LEN_MSB      = 4;
  localparam int          LEN_LSB      = 2;
  localparam int          B_DIR        = 1;
  localparam int          B_CLASSIC    = 0;

  // ----------------------------------------------------------------
  // write masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  IRQ_EN_WMASK = 8'hf7;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [3:0]  RST_GLB      = 4'h0;

  // request sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_HEADER = 2'b01,
    SEQ_WAKE   = 2'b10,
    SEQ_ABORT  = 2'b11
  } seq_state_type;

endpackage

/* hdl/lin_req_seq.sv */
// per-channel header, wake-up and abort request sequencer
`timescale 1ns/1ps
module lin_req_seq
  import lin_frame_ctrl_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic req_wr,
  input  wire logic req_hdr,
  input  wire logic req_wake,
  input  wire logic req_abort,
  input  wire logic op_done,
  input  wire logic bit_end,
  output logic      hdr_req_q,
  output logic      wake_req_q,
  output logic      abort_req_q,
  output logic      hdr_start_q,
  output logic      wake_start_q,
  output logic      abort_now_q,
  output logic      readback_chk_q
);

  seq_state_type state_q;
  seq_state_type state_d;

  // next state; a header written with abort wins, abort alone when idle is dropped
  always_comb begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE: begin
        if (req_wr && req_hdr) state_d = SEQ_HEADER; // RULE11 RULE12
        else if (req_wr && req_wake) state_d = SEQ_WAKE; // RULE8
      end
      SEQ_HEADER, SEQ_WAKE: begin
        if (op_done) state_d = SEQ_IDLE; // RULE13
        else if (req_wr && req_abort && !req_hdr) state_d = SEQ_ABORT; // RULE11
      end
      SEQ_ABORT: begin
        if (bit_end || op_done) state_d = SEQ_IDLE; // RULE10
      end
      default: state_d = SEQ_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) state_q <= SEQ_IDLE;
    else state_q <= state_d;
  end

  // request bits self-clear on completion or abort; abort never sets when idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hdr_req_q   <= 1'b0;
      wake_req_q  <= 1'b0;
      abort_req_q <= 1'b0;
    end else begin
      if (state_d == SEQ_IDLE) begin
        hdr_req_q  <= 1'b0; // RULE13
        wake_req_q <= 1'b0; // RULE13
      end else if (state_q == SEQ_IDLE) begin
        hdr_req_q  <= state_d == SEQ_HEADER;
        wake_req_q <= state_d == SEQ_WAKE;
      end
      abort_req_q <= state_d == SEQ_ABORT; // RULE10 RULE20
    end
  end

  // one-cycle strobes to the frame engine; readback off during wake-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hdr_start_q    <= 1'b0;
      wake_start_q   <= 1'b0;
      abort_now_q    <= 1'b0;
      readback_chk_q <= 1'b1;
    end else begin
      hdr_start_q    <= state_q == SEQ_IDLE && state_d == SEQ_HEADER; // RULE12
      wake_start_q   <= state_q == SEQ_IDLE && state_d == SEQ_WAKE; // RULE8
      abort_now_q    <= state_q == SEQ_ABORT && bit_end && !op_done; // RULE10
      readback_chk_q <= !(state_d == SEQ_WAKE || (state_d == SEQ_ABORT && wake_req_q)); // RULE9
    end
  end

endmodule

/* hdl/lin_irq_gate.sv */
// per-channel interrupt source gating
`timescale 1ns/1ps
module lin_irq_gate
  import lin_frame_ctrl_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [7:0]        irq_en,
  input  wire logic [ERR_W-1:0]  err_flags,
  input  wire logic [STAT_W-1:0] stat_flags,
  input  wire logic              global_en,
  output logic                   chan_irq_q
);

  logic [7:0] src;

  // line the flags up with their enable bits; the reserved slot stays low
  always_comb begin
    src          = RST_BYTE;
    src[B_STUCK] = err_flags[4];
    src[B_TMO]   = err_flags[3];
    src[B_RDBK]  = err_flags[2];
    src[B_SUM]   = err_flags[1];
    src[B_FRM]   = err_flags[0];
    src[B_RXD]   = stat_flags[1];
    src[B_TXD]   = stat_flags[0];
  end

  // registered so the pin never glitches while flags settle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) chan_irq_q <= 1'b0;
    else chan_irq_q <= global_en && |(src & irq_en); // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE19
  end

endmodule

/* hdl/lin_frame_ctrl.sv */
// lin master frame request registers for four channels, apb slave
//
// Functional notes
// RULE1 - bit 7 gates stuck-low flag, resets off
// RULE2 - bit 6 gates response timeout flag
// RULE3 - bit 5 gates readback error flag
// RULE4 - bit 4 gates checksum mismatch flag
// RULE5 - bit 0 gates framing error; bit 3 zero
// RULE6 - bit 2 gates reception done flag
// RULE7 - bit 1 gates transmission done flag
// RULE8 - wake-up sends buffer byte 1 when requested
// RULE9 - no readback checking during wake-up
// RULE10 - abort at bit end, then self-clears
// RULE11 - header plus abort together: abort ignored
// RULE12 - header request starts header, response follows
// RULE13 - header and wake-up bits self-clear
// RULE14 - identifier six bits, upper bits read zero
// RULE15 - length field holds byte count minus one
// RULE16 - direction one means master transmits response
// RULE17 - checksum bit one selects classic checksum
// RULE18 - four channel copies spaced 30h apart
// RULE19 - interrupt needs source and global enable
// RULE20 - abort while idle clears at once
`timescale 1ns/1ps
module lin_frame_ctrl
  import lin_frame_ctrl_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // frame engine, same clock
  input  wire logic [CHANS-1:0]        op_done,
  input  wire logic [CHANS-1:0]        bit_end,
  input  wire logic [CHANS*ERR_W-1:0]  err_flags,
  input  wire logic [CHANS*STAT_W-1:0] stat_flags,
  output logic      [CHANS-1:0]        hdr_start,
  output logic      [CHANS-1:0]        wake_start,
  output logic      [CHANS-1:0]        abort_now,
  output logic      [CHANS-1:0]        readback_chk_en,
  output logic      [CHANS*6-1:0]      frame_id,
  output logic      [CHANS*3-1:0]      payload_len_minus1,
  output logic      [CHANS-1:0]        resp_dir_tx,
  output logic      [CHANS-1:0]        classic_sum,
  output logic      [CHANS-1:0]        chan_irq
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0]       irq_en_q   [CHANS];
  logic [ID_MSB:0]  ident_q    [CHANS];
  logic [LEN_MSB:0] format_q   [CHANS];
  logic [CHANS-1:0] glb_en_q;

  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;

  logic [CHANS-1:0] hdr_req;
  logic [CHANS-1:0] wake_req;
  logic [CHANS-1:0] abort_req;
  logic [CHANS-1:0] req_wr;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic             acc_phase;
  logic             wr_now;
  logic             hit;
  logic [7:0]       rd_byte;

  assign idx       = paddr[ADDR_W-1:2];
  assign acc_phase = psel && penable;
  // write lands on the edge where the master sees pready high
  assign wr_now    = acc_phase && pready_q && pwrite;

  // index of register off in channel ch
  function automatic logic [IDX_W-1:0] chan_idx(
    input logic [IDX_W-1:0] off,
    input int               ch
  );
    logic [IDX_W-1:0] step;
    step = IDX_W'(ch) * CHAN_STRIDE; // RULE18
    return off + step;
  endfunction

  // true when idx selects register off of channel ch
  function automatic logic sel(
    input logic [IDX_W-1:0] a,
    input logic [IDX_W-1:0] off,
    input int               ch
  );
    return a == chan_idx(off, ch);
  endfunction

  // read mux and hit detect; unmapped reads give zero and an error
  always_comb begin
    rd_byte = RST_BYTE;
    hit     = 1'b0;
    if (idx == IDX_GLB_EN) begin
      hit     = 1'b1;
      rd_byte = {4'h0, glb_en_q};
    end
    for (int c = 0; c < CHANS; c++) begin
      if (sel(idx, IDX_IRQ_EN, c)) begin
        hit     = 1'b1;
        rd_byte = irq_en_q[c]; // RULE5
      end
      if (sel(idx, IDX_REQ, c)) begin
        hit     = 1'b1;
        rd_byte = RST_BYTE;
        rd_byte[B_WAKE]  = wake_req[c];
        rd_byte[B_ABORT] = abort_req[c];
        rd_byte[B_HDR]   = hdr_req[c];
      end
      if (sel(idx, IDX_ID, c)) begin
        hit     = 1'b1;
        rd_byte = {2'b00, ident_q[c]}; // RULE14
      end
      if (sel(idx, IDX_FMT, c)) begin
        hit     = 1'b1;
        rd_byte = {3'b000, format_q[c]};
      end
    end
  end

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------

  // one wait state: pready rises the cycle after the access phase opens,
  // which keeps every bus output coming from a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pready_q <= 1'b0;
    else pready_q <= acc_phase && !pready_q;
  end

  // read data and error are captured together with pready
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (acc_phase && !pready_q) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_q <= !hit;
    end else begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // global enable
  // ----------------------------------------------------------------

  // one enable bit per channel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) glb_en_q <= RST_GLB;
    else if (wr_now && idx == IDX_GLB_EN) glb_en_q <= pwdata[CHANS-1:0]; // RULE19
  end

  // ----------------------------------------------------------------
  // per-channel registers and helpers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CHANS; g++) begin : g_chan

    // interrupt enables; reserved bit never stores
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) irq_en_q[g] <= RST_BYTE; // RULE1
      else if (wr_now && sel(idx, IDX_IRQ_EN, g)) irq_en_q[g] <= pwdata[7:0] & IRQ_EN_WMASK; // RULE5
    end

    // frame identifier, parity added by the engine
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) ident_q[g] <= RST_BYTE[ID_MSB:0];
      else if (wr_now && sel(idx, IDX_ID, g)) ident_q[g] <= pwdata[ID_MSB:0]; // RULE14
    end

    // length, direction and checksum kind
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) format_q[g] <= RST_BYTE[LEN_MSB:0];
      else if (wr_now && sel(idx, IDX_FMT, g)) format_q[g] <= pwdata[LEN_MSB:0]; // RULE15 RULE16 RULE17
    end

    // a write to the request register is handed to the sequencer
    assign req_wr[g] = wr_now && sel(idx, IDX_REQ, g);

    // request sequencer
    lin_req_seq u_seq (
      .clk_sys        (clk_sys),
      .rst_n          (rst_n),
      .req_wr         (req_wr[g]),
      .req_hdr        (pwdata[B_HDR]),
      .req_wake       (pwdata[B_WAKE]),
      .req_abort      (pwdata[B_ABORT]),
      .op_done        (op_done[g]),
      .bit_end        (bit_end[g]),
      .hdr_req_q      (hdr_req[g]),
      .wake_req_q     (wake_req[g]),
      .abort_req_q    (abort_req[g]),
      .hdr_start_q    (hdr_start[g]),
      .wake_start_q   (wake_start[g]),
      .abort_now_q    (abort_now[g]),
      .readback_chk_q (readback_chk_en[g])
    );

    // interrupt gate
    lin_irq_gate u_irq (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .irq_en     (irq_en_q[g]),
      .err_flags  (err_flags[g*ERR_W +: ERR_W]),
      .stat_flags (stat_flags[g*STAT_W +: STAT_W]),
      .global_en  (glb_en_q[g]),
      .chan_irq_q (chan_irq[g])
    );

    // configuration straight from its flops to the engine
    assign frame_id[g*6 +: 6]           = ident_q[g];
    assign payload_len_minus1[g*3 +: 3] = format_q[g][LEN_MSB:LEN_LSB]; // RULE15
    assign resp_dir_tx[g]               = format_q[g][B_DIR]; // RULE16 RULE12
    assign classic_sum[g]               = format_q[g][B_CLASSIC]; // RULE17

  end

endmodule

/* verif/lin_frame_ctrl_assertions.sv */
// port-level checker for the lin frame request block
`timescale 1ns/1ps
module lin_frame_ctrl_assertions
  import lin_frame_ctrl_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [ADDR_W-1:0]       paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [CHANS-1:0]        op_done,
  input wire logic [CHANS-1:0]        bit_end,
  input wire logic [CHANS*ERR_W-1:0]  err_flags,
  input wire logic [CHANS*STAT_W-1:0] stat_flags,
  input wire logic [CHANS-1:0]        hdr_start,
  input wire logic [CHANS-1:0]        wake_start,
  input wire logic [CHANS-1:0]        abort_now,
  input wire logic [CHANS-1:0]        readback_chk_en,
  input wire logic [CHANS*6-1:0]      frame_id,
  input wire logic [CHANS*3-1:0]      payload_len_minus1,
  input wire logic [CHANS-1:0]        resp_dir_tx,
  input wire logic [CHANS-1:0]        classic_sum,
  input wire logic [CHANS-1:0]        chan_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // a completed write; the register only changes on this edge
  logic wr_ok;
  assign wr_ok = psel && penable && pready && pwrite;
  property p_apb_wait; psel && penable && !pready |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  property p_unmapped; pready && paddr[11:2] == 10'h3ff |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_hdr; $rose(hdr_start[0]) |-> $past(wr_ok && paddr == {IDX_REQ, 2'b00} && pwdata[B_HDR]); endproperty
  a_hdr: assert property (p_hdr) else $error("header start without request");
  property p_wake; $rose(wake_start[0]) |-> $past(wr_ok && paddr == {IDX_REQ, 2'b00} && pwdata[B_WAKE]); endproperty
  a_wake: assert property (p_wake) else $error("wake start without request");
  property p_abort; abort_now[0] |-> $past(bit_end[0]); endproperty
  a_abort: assert property (p_abort) else $error("abort off bit boundary");
  property p_rdbk; $fell(readback_chk_en[0]) |-> wake_start[0] || $past(wake_start[0]); endproperty
  a_rdbk: assert property (p_rdbk) else $error("readback check dropped outside wake");
  property p_irq; chan_irq[0] |-> $past((|err_flags[4:0]) || (|stat_flags[1:0])); endproperty
  a_irq: assert property (p_irq) else $error("interrupt with no source");
  property p_id; wr_ok && paddr == {IDX_ID, 2'b00} |=> frame_id[5:0] == $past(pwdata[5:0]); endproperty
  a_id: assert property (p_id) else $error("identifier not stored");
  property p_fmt;
    wr_ok && paddr == {IDX_FMT, 2'b00} |=>
      {payload_len_minus1[2:0], resp_dir_tx[0], classic_sum[0]} == $past(pwdata[4:0]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format not stored");
  // header plus abort in one write: the abort must leave no trace
  property p_hdr_abort; wr_ok && paddr == {IDX_REQ, 2'b00} && pwdata[1:0] == 2'b11 |=> !abort_now[0] [*4]; endproperty
  a_hdr_abort: assert property (p_hdr_abort) else $error("abort acted with header");
  c_hdr: cover property (hdr_start[0]);
  c_wake: cover property (wake_start[0]);
  c_abort: cover property (abort_now[0]);
  c_irq: cover property (chan_irq[0]);
endmodule
bind lin_frame_ctrl lin_frame_ctrl_assertions chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .op_done(op_done), .bit_end(bit_end), .err_flags(err_flags), .stat_flags(stat_flags),
  .hdr_start(hdr_start), .wake_start(wake_start), .abort_now(abort_now), .readback_chk_en(readback_chk_en),
  .frame_id(frame_id), .payload_len_minus1(payload_len_minus1), .resp_dir_tx(resp_dir_tx),
  .classic_sum(classic_sum), .chan_irq(chan_irq));

/* verif/lin_bus_partner.sv */
// behavioural frame engine and bus bit timing
`timescale 1ns/1ps
module lin_bus_partner
  import lin_frame_ctrl_pkg::*;
#(
  parameter int HDR_BITS  = 34,
  parameter int WAKE_BITS = 10
)
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               slow,
  input  wire logic [CHANS-1:0]   hdr_start,
  input  wire logic [CHANS-1:0]   wake_start,
  input  wire logic [CHANS-1:0]   abort_now,
  input  wire logic [CHANS*3-1:0] payload_len_minus1,
  output logic      [CHANS-1:0]   op_done,
  output logic      [CHANS-1:0]   bit_end
);
  for (genvar c = 0; c < CHANS; c++) begin : g_ch
    logic [7:0] left_q;
    logic [1:0] div_q;
    logic       end_q;
    logic       done_q;
    // a bit lasts one clock, or four when slow, so aborts land mid-frame
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        left_q <= 8'h00;
        div_q  <= 2'h0;
        end_q  <= 1'b0;
        done_q <= 1'b0;
      end else begin
        end_q  <= 1'b0;
        done_q <= 1'b0;
        div_q  <= div_q + 2'h1;
        if (abort_now[c]) begin
          left_q <= 8'h00;
        end else if (hdr_start[c]) begin
          left_q <= 8'(HDR_BITS + 10 * (payload_len_minus1[c*3+:3] + 2));
        end else if (wake_start[c]) begin
          left_q <= 8'(WAKE_BITS);
        end else if (left_q != 8'h00 && (!slow || div_q == 2'h3)) begin
          end_q  <= 1'b1;
          left_q <= left_q - 8'h01;
          done_q <= (left_q == 8'h01);
        end
      end
    end
    assign op_done[c] = done_q;
    assign bit_end[c] = end_q;
  end
endmodule

/* verif/tb_lin_master_frame_control.sv */
// self-checking bench for the lin frame request block
`timescale 1ns/1ps
module tb_lin_master_frame_control;
  import lin_frame_ctrl_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rnd = 32'h7aadf078, rd, prdata;
  logic        se, pready, pslverr;
  logic [3:0]  op_done, bit_end, hdr_start, wake_start, abort_now, rdbk_en, resp_dir_tx, classic_sum, chan_irq, ev, g_m;
  logic [19:0] err_flags = 20'h0;
  logic [7:0]  stat_flags = 8'h0;
  logic [7:0]  en_m [CHANS];
  logic [23:0] frame_id;
  logic [11:0] plen;
  int          error_cnt = 0, checks = 0, aborts = 0, n0;
  lin_frame_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_done(op_done),
    .bit_end(bit_end), .err_flags(err_flags), .stat_flags(stat_flags), .hdr_start(hdr_start),
    .wake_start(wake_start), .abort_now(abort_now), .readback_chk_en(rdbk_en), .frame_id(frame_id),
    .payload_len_minus1(plen), .resp_dir_tx(resp_dir_tx), .classic_sum(classic_sum), .chan_irq(chan_irq));
  lin_bus_partner eng_u (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .hdr_start(hdr_start),
    .wake_start(wake_start), .abort_now(abort_now), .payload_len_minus1(plen), .op_done(op_done), .bit_end(bit_end));
  initial forever #4 clk_sys = ~clk_sys;
  // counted off the edge so the pulse is seen settled
  always @(negedge clk_sys) if (abort_now[0] === 1'b1) aborts++;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [11:0] ra(input int c, input logic [9:0] i);
    return {i + CHAN_STRIDE * 10'(c), 2'b00};
  endfunction
  function automatic logic exp_irq(input logic [7:0] en, input logic [4:0] e, input logic [1:0] s, input logic g);
    return g & (|(en & {e[4:1], 1'b0, s, e[0]}));
  endfunction
  // apb master: request held until the rising edge that sees pready, data taken there, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    se = pslverr;
    if (n >= 16) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic rdchk(input int c, input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, ra(c, i), 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_done(input int c);
    int n;
    n = 0;
    while (op_done[c] !== 1'b1 && n < 2000) begin @(negedge clk_sys); n++; end
    if (n >= 2000) error_cnt++;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int c = 0; c < CHANS; c++) begin
      for (int i = 0; i < 4; i++) rdchk(c, IDX_IRQ_EN + 10'(i), 32'h0);
      rnd = lfsr(rnd);
      en_m[c] = rnd[7:0];
      apb(1'b1, ra(c, IDX_IRQ_EN), rnd);
      rdchk(c, IDX_IRQ_EN, {24'h0, rnd[7:0] & IRQ_EN_WMASK});
      apb(1'b1, ra(c, IDX_ID), rnd >> 8);
      rdchk(c, IDX_ID, {26'h0, rnd[13:8]});
      chk(32'(frame_id[c*6+:6]), 32'(rnd[13:8]));
      apb(1'b1, ra(c, IDX_FMT), rnd >> 16);
      rdchk(c, IDX_FMT, {27'h0, rnd[20:16]});
      chk(32'({plen[c*3+:3], resp_dir_tx[c], classic_sum[c]}), 32'(rnd[20:16]));
    end
    apb(1'b0, 12'hffc, 32'h0);
    chk({rd[31:1], se}, 32'h1);
    // random enables, global gates and sparse flags on all channels
    for (int k = 0; k < 32; k++) begin
      rnd = lfsr(rnd);
      en_m[k % 4] = rnd[7:0];
      g_m = rnd[11:8];
      apb(1'b1, ra(k % 4, IDX_IRQ_EN), rnd);
      apb(1'b1, {IDX_GLB_EN, 2'b00}, {28'h0, g_m});
      rnd = lfsr(rnd);
      err_flags <= rnd[19:0] & rnd[31:12];
      stat_flags <= rnd[7:0] & rnd[31:24];
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      for (int c = 0; c < CHANS; c++) ev[c] = exp_irq(en_m[c], err_flags[c*5+:5], stat_flags[c*2+:2], g_m[c]);
      chk(32'(chan_irq), 32'(ev));
    end
    for (int c = 0; c < CHANS; c++) begin
      slow <= c[0];
      apb(1'b1, ra(c, IDX_FMT), 32'h0000001e);
      apb(1'b1, ra(c, IDX_REQ), 32'h00000001);
      rdchk(c, IDX_REQ, 32'h1);
      wait_done(c);
      rdchk(c, IDX_REQ, 32'h0);
    end
    apb(1'b1, ra(0, IDX_REQ), 32'h00000010);
    rdchk(0, IDX_REQ, 32'h10);
    chk(32'(rdbk_en[0]), 32'h0);
    wait_done(0);
    rdchk(0, IDX_REQ, 32'h0);
    chk(32'(rdbk_en[0]), 32'h1);
    // abort a header, then a wake-up, while a slow bus keeps them busy
    for (int k = 0; k < 2; k++) begin
      n0 = aborts;
      apb(1'b1, ra(0, IDX_REQ), k ? 32'h10 : 32'h01);
      apb(1'b1, ra(0, IDX_REQ), 32'h00000002);
      repeat (8) @(posedge clk_sys);
      rdchk(0, IDX_REQ, 32'h0);
      chk(32'(aborts - n0), 32'h1);
    end
    n0 = aborts;
    apb(1'b1, ra(0, IDX_REQ), 32'h00000003);
    rdchk(0, IDX_REQ, 32'h1);
    wait_done(0);
    chk(32'(aborts - n0), 32'h0);
    apb(1'b1, ra(0, IDX_REQ), 32'h00000002);
    rdchk(0, IDX_REQ, 32'h0);
    give_verdict();
  end
endmodule
